/* rtl/shcsr_device.sv */
// Sensor side: host-visible configuration, command and status registers
// Contract
// - Config bit 6 selects alert polarity
// - Config bit 5: open drain or push-pull
// - Config bit 3 alerts on new mailbox
// - Config bit 2 alerts on threshold hit
// - Config bit 1 alerts on new results
// - Config bit 0 master enable, resets zero
// - Commands run only in idle mode
// - Host loads write mailbox before command
// - Version fetch fills mailbox bytes 0, 1
// - Temperature taken on high byte write
// - Temperature is kelvin times 64
// - Humidity taken on high byte write
// - Humidity is percent times 512
// - Status bit 7 shows mode running
// - Status bit 6 flags detected errors
// - Rejected mode code goes into read mailbox byte 0
// - Status bit 4 flags threshold reached
// - Status bit 1 new results, read clears
// - Status bit 0 new mailbox, read clears
// - Mode codes: sleep, idle, reset, sensing
`timescale 1ns/1ns
`default_nettype none
module shcsr_device #(
   parameter logic [3:0] REL_CODE = 4'h1, // Arbitrary value
   parameter logic [3:0] VER_CODE = 4'h0, // Arbitrary value
   parameter logic [7:0] SUB_CODE = 8'h00 // Arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   shcsr_if.device          bus,
   input  wire logic [15:0] result_tvoc,
   input  wire logic [15:0] result_eco2,
   input  wire logic        result_load,
   input  wire logic        threshold_hit,
   output logic [7:0]       operating_mode_reg,
   output logic [15:0]      temp_comp,
   output logic [15:0]      rh_comp,
   output logic             comp_update
);
   // ==========================================================
   // Decode
   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_range

   localparam int MBOX_N = shcsr_pkg::MBOX_N;

   logic [7:0]  config_q;
   logic [7:0]  command_q;
   logic        cmd_pending_q;
   logic [15:0] tvoc_q;
   logic [15:0] eco2_q;
   logic [7:0]  temp_lo_q;
   logic [7:0]  rh_lo_q;
   logic [7:0]  wmbox_q [MBOX_N];
   logic [7:0]  rmbox_q [MBOX_N];
   logic        new_mailbox_flag_q;
   logic        new_result_flag_q;
   logic        threshold_hit_flag_q;
   logic        error_flag_q;
   logic        wr_mode;
   logic        soft_rst;
   logic        mode_valid;
   logic        cmd_exec;
   logic        mbox_fill;
   logic        alert_active;
   logic [7:0]  status;
   logic [7:0]  rd_d;

   assign wr_mode  = bus.wr && (bus.addr == shcsr_pkg::A_OPERATING_MODE_REG);
   assign soft_rst = sys_rst || (wr_mode && (bus.wdata == shcsr_pkg::MODE_SWRST));
   assign mode_valid = (bus.wdata == shcsr_pkg::MODE_SLEEP) ||
                       (bus.wdata == shcsr_pkg::MODE_IDLE) ||
                       (bus.wdata == shcsr_pkg::MODE_GAS);
   assign cmd_exec = cmd_pending_q && (operating_mode_reg == shcsr_pkg::MODE_IDLE);
   assign mbox_fill = cmd_exec && (command_q == shcsr_pkg::CMD_FETCH_VERSION);

   // ==========================================================
   // Operating mode and error flag
   always_ff @(posedge clk) begin
      if (soft_rst) begin
         operating_mode_reg <= shcsr_pkg::MODE_IDLE;
      end else if (wr_mode && mode_valid) begin
         operating_mode_reg <= bus.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         error_flag_q <= 1'b0;
      end else if (wr_mode && !mode_valid) begin
         error_flag_q <= 1'b1;
      end else if (cmd_exec && !mbox_fill) begin
         error_flag_q <= 1'b1;
      end else if (wr_mode) begin
         error_flag_q <= 1'b0;
      end
   end

   // ==========================================================
   // Configuration, command and compensation inputs
   always_ff @(posedge clk) begin
      if (soft_rst) begin
         config_q <= shcsr_pkg::ZERO8;
      end else if (bus.wr && bus.addr == shcsr_pkg::A_CONFIG) begin
         config_q <= bus.wdata & shcsr_pkg::CFG_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         command_q     <= shcsr_pkg::CMD_NOP;
         cmd_pending_q <= 1'b0;
      end else if (bus.wr && bus.addr == shcsr_pkg::A_COMMAND) begin
         command_q     <= bus.wdata;
         cmd_pending_q <= 1'b1;
      end else if (cmd_exec) begin
         cmd_pending_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      comp_update <= 1'b0;
      if (soft_rst) begin
         temp_lo_q   <= shcsr_pkg::ZERO8;
         rh_lo_q     <= shcsr_pkg::ZERO8;
         temp_comp   <= shcsr_pkg::ZERO16;
         rh_comp     <= shcsr_pkg::ZERO16;
      end else if (bus.wr) begin
         unique case (bus.addr)
            shcsr_pkg::A_TEMP_LO: temp_lo_q <= bus.wdata;
            shcsr_pkg::A_RH_LO:   rh_lo_q   <= bus.wdata;
            shcsr_pkg::A_TEMP_HI: begin
               temp_comp   <= {bus.wdata, temp_lo_q};
               comp_update <= 1'b1;
            end
            shcsr_pkg::A_RH_HI: begin
               rh_comp     <= {bus.wdata, rh_lo_q};
               comp_update <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Mailboxes and results
   always_ff @(posedge clk) begin
      if (soft_rst) begin
         for (int i = 0; i < MBOX_N; i++) begin
            wmbox_q[i] <= shcsr_pkg::ZERO8;
         end
      end else if (bus.wr && in_range(bus.addr, shcsr_pkg::A_WMBOX,
                                      shcsr_pkg::A_RMBOX - 8'h01)) begin
         wmbox_q[bus.addr[2:0]] <= bus.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         for (int i = 0; i < MBOX_N; i++) begin
            rmbox_q[i] <= shcsr_pkg::ZERO8;
         end
      // rejected mode code as error detail
      end else if (wr_mode && !mode_valid) begin
         rmbox_q[0] <= bus.wdata;
      end else if (mbox_fill) begin
         rmbox_q[0] <= {REL_CODE, VER_CODE};
         rmbox_q[1] <= SUB_CODE;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         tvoc_q <= shcsr_pkg::ZERO16;
         eco2_q <= shcsr_pkg::ZERO16;
      end else if (result_load) begin
         tvoc_q <= result_tvoc;
         eco2_q <= result_eco2;
      end
   end

   // ==========================================================
   // Status flags; a set in the clearing cycle wins
   always_ff @(posedge clk) begin
      if (soft_rst) begin
         new_mailbox_flag_q <= 1'b0;
      // set on fill, clear on mailbox read
      end else if (mbox_fill || (wr_mode && !mode_valid)) begin
         new_mailbox_flag_q <= 1'b1;
      end else if (bus.rd && in_range(bus.addr, shcsr_pkg::A_RMBOX,
                                      shcsr_pkg::A_RMBOX_HI)) begin
         new_mailbox_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         new_result_flag_q <= 1'b0;
      // set on load, clear on result read
      end else if (result_load) begin
         new_result_flag_q <= 1'b1;
      end else if (bus.rd && in_range(bus.addr, shcsr_pkg::A_RES_LO,
                                      shcsr_pkg::A_RES_HI)) begin
         new_result_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (soft_rst) begin
         threshold_hit_flag_q <= 1'b0;
      end else if (threshold_hit) begin
         threshold_hit_flag_q <= 1'b1;
      end else if (bus.rd && bus.addr == shcsr_pkg::A_STATUS) begin
         threshold_hit_flag_q <= 1'b0;
      end
   end

   always_comb begin
      status = shcsr_pkg::ZERO8;
      status[shcsr_pkg::ST_RUN] = (operating_mode_reg == shcsr_pkg::MODE_GAS);
      status[shcsr_pkg::ST_ERR] = error_flag_q;
      status[shcsr_pkg::ST_TH]  = threshold_hit_flag_q;
      status[shcsr_pkg::ST_RES] = new_result_flag_q;
      status[shcsr_pkg::ST_MBX] = new_mailbox_flag_q;
   end

   // ==========================================================
   // Read port: data stands in the cycle after the strobe
   always_comb begin
      rd_d = shcsr_pkg::ZERO8;
      if (in_range(bus.addr, shcsr_pkg::A_WMBOX, shcsr_pkg::A_RMBOX - 8'h01)) begin
         rd_d = wmbox_q[bus.addr[2:0]];
      end else if (in_range(bus.addr, shcsr_pkg::A_RMBOX, shcsr_pkg::A_RMBOX_HI)) begin
         rd_d = rmbox_q[bus.addr[2:0]];
      end else begin
         unique case (bus.addr)
            shcsr_pkg::A_OPERATING_MODE_REG:         rd_d = operating_mode_reg;
            shcsr_pkg::A_CONFIG:         rd_d = config_q;
            shcsr_pkg::A_COMMAND:        rd_d = command_q;
            shcsr_pkg::A_TEMP_LO:        rd_d = temp_lo_q;
            shcsr_pkg::A_TEMP_HI:        rd_d = temp_comp[15:8];
            shcsr_pkg::A_RH_LO:          rd_d = rh_lo_q;
            shcsr_pkg::A_RH_HI:          rd_d = rh_comp[15:8];
            shcsr_pkg::A_STATUS:         rd_d = status;
            shcsr_pkg::A_TVOC:           rd_d = tvoc_q[7:0];
            shcsr_pkg::A_TVOC + 8'h01:   rd_d = tvoc_q[15:8];
            shcsr_pkg::A_ECO2:           rd_d = eco2_q[7:0];
            shcsr_pkg::A_ECO2 + 8'h01:   rd_d = eco2_q[15:8];
            default:                     rd_d = shcsr_pkg::ZERO8;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus.rdata <= shcsr_pkg::ZERO8;
      end else if (bus.rd) begin
         bus.rdata <= rd_d;
      end else begin
         bus.rdata <= shcsr_pkg::ZERO8;
      end
   end

   // ==========================================================
   // Alert pin: a level that follows the enabled sticky flags
   // master enable gates
   assign alert_active = config_q[shcsr_pkg::CFG_EN] &&
      ((config_q[shcsr_pkg::CFG_MBX] && new_mailbox_flag_q) ||
       (config_q[shcsr_pkg::CFG_TH]  && threshold_hit_flag_q) ||
       (config_q[shcsr_pkg::CFG_RES] && new_result_flag_q));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus.alert_pin_n_o  <= 1'b0;
         bus.alert_pin_n_oe <= 1'b0;
      end else if (config_q[shcsr_pkg::CFG_PP]) begin
         bus.alert_pin_n_o  <= config_q[shcsr_pkg::CFG_POL] ~^ alert_active;
         bus.alert_pin_n_oe <= 1'b1;
      end else begin
         // Open drain only pulls low; high comes from the pull-up
         bus.alert_pin_n_o  <= 1'b0;
         bus.alert_pin_n_oe <= config_q[shcsr_pkg::CFG_POL] ^ alert_active;
      end
   end
endmodule : shcsr_device
`default_nettype wire

/* rtl/shcsr_host.sv */
// Host side: issues register accesses and watches the alert pin
`timescale 1ns/1ns
`default_nettype none
module shcsr_host (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   shcsr_if.host            bus,
   input  wire logic [7:0]  user_addr,
   input  wire logic [7:0]  user_wdata,
   input  wire logic [15:0] user_wdata16,
   input  wire logic        user_wr,
   input  wire logic        user_word_wr,
   input  wire logic        user_rd,
   output logic [7:0]       user_rdata,
   output logic             user_rvalid,
   output logic             busy,
   output logic             alert_seen
);
   logic       rd_pend_q;
   logic       hi_pend_q;
   logic [7:0] hi_byte_q;
   logic       pol_q;
   logic [2:0] pol_pipe_q;
   logic       alert_sync;

   // ==========================================================
   // Bus sequencer; user strobes are ignored while busy
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus.addr  <= shcsr_pkg::ZERO8;
         bus.wdata <= shcsr_pkg::ZERO8;
         bus.wr    <= 1'b0;
         bus.rd    <= 1'b0;
         hi_pend_q <= 1'b0;
         hi_byte_q <= shcsr_pkg::ZERO8;
      end else if (hi_pend_q) begin
         bus.addr  <= bus.addr + 8'h01;
         bus.wdata <= hi_byte_q;
         bus.wr    <= 1'b1;
         bus.rd    <= 1'b0;
         hi_pend_q <= 1'b0;
      end else if (user_word_wr) begin
         // low byte is the fraction, sent first
         bus.addr  <= user_addr;
         bus.wdata <= user_wdata16[7:0];
         bus.wr    <= 1'b1;
         bus.rd    <= 1'b0;
         hi_pend_q <= 1'b1;
         hi_byte_q <= user_wdata16[15:8];
      end else begin
         // mailbox and command writes go out in issue order
         bus.addr  <= user_addr;
         bus.wdata <= user_wdata;
         bus.wr    <= user_wr;
         bus.rd    <= user_rd && !user_wr;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy <= 1'b0;
      end else begin
         busy <= user_word_wr && !hi_pend_q;
      end
   end

   // ==========================================================
   // Read return
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_pend_q   <= 1'b0;
         user_rvalid <= 1'b0;
         user_rdata  <= shcsr_pkg::ZERO8;
      end else begin
         rd_pend_q   <= bus.rd;
         user_rvalid <= rd_pend_q;
         if (rd_pend_q) begin
            user_rdata <= bus.rdata;
         end
      end
   end

   // ==========================================================
   // Alert: track polarity from configuration writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pol_q <= 1'b0;
      // A soft reset clears the configuration, so the shadow follows it
      end else if (bus.wr && bus.addr == shcsr_pkg::A_OPERATING_MODE_REG &&
                   bus.wdata == shcsr_pkg::MODE_SWRST) begin
         pol_q <= 1'b0;
      end else if (bus.wr && bus.addr == shcsr_pkg::A_CONFIG) begin
         pol_q <= bus.wdata[shcsr_pkg::CFG_POL];
      end
   end

   shcsr_sync2 #(.RESET_VAL(1'b1)) u_alert_sync (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in (bus.alert_pin_n_level),
      .sync_out (alert_sync)
   );

   always_ff @(posedge clk) begin
      // Polarity is delayed to match pin register plus synchroniser lag,
      // otherwise a polarity change shows a false alert for three cycles
      if (sys_rst) begin
         pol_pipe_q <= 3'h0;
         alert_seen <= 1'b0;
      end else begin
         pol_pipe_q <= {pol_pipe_q[1:0], pol_q};
         alert_seen <= alert_sync ~^ pol_pipe_q[2];
      end
   end
endmodule : shcsr_host
`default_nettype wire

/* rtl/shcsr_if.sv */
// Register bus and alert pin between host and sensor register bank
`timescale 1ns/1ns
`default_nettype none
interface shcsr_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       alert_pin_n_o;
   logic       alert_pin_n_oe;
   logic       alert_pin_n_level;

   // Board pull-up: an undriven open-drain line floats high
   assign alert_pin_n_level = alert_pin_n_oe ? alert_pin_n_o : 1'b1;

   modport device (
      input  addr, wdata, wr, rd,
      output rdata, alert_pin_n_o, alert_pin_n_oe
   );
   modport host (
      output addr, wdata, wr, rd,
      input  rdata, alert_pin_n_level
   );
endinterface : shcsr_if
`default_nettype wire

/* rtl/shcsr_pkg.sv */
// Shared constants for the gas sensor host register bank and its host
package shcsr_pkg;
   // ==========================================================
   // Widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int MBOX_N = 8;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] A_OPERATING_MODE_REG   = 8'h10;
   localparam logic [7:0] A_CONFIG   = 8'h11;
   localparam logic [7:0] A_COMMAND  = 8'h12;
   localparam logic [7:0] A_TEMP_LO  = 8'h13;
   localparam logic [7:0] A_TEMP_HI  = 8'h14;
   localparam logic [7:0] A_RH_LO    = 8'h15;
   localparam logic [7:0] A_RH_HI    = 8'h16;
   localparam logic [7:0] A_STATUS   = 8'h20;
   localparam logic [7:0] A_RES_LO   = 8'h22;
   localparam logic [7:0] A_RES_HI   = 8'h37;
   localparam logic [7:0] A_TVOC     = 8'h22;
   localparam logic [7:0] A_ECO2     = 8'h24;
   localparam logic [7:0] A_WMBOX    = 8'h40;
   localparam logic [7:0] A_RMBOX    = 8'h48;
   localparam logic [7:0] A_RMBOX_HI = 8'h4f;
   // ==========================================================
   // Configuration fields
   localparam int CFG_EN   = 0;
   localparam int CFG_RES  = 1;
   localparam int CFG_TH   = 2;
   localparam int CFG_MBX  = 3;
   localparam int CFG_PP   = 5;
   localparam int CFG_POL  = 6;
   localparam logic [7:0] CFG_MASK = 8'h6f;
   // ==========================================================
   // Status fields
   localparam int ST_MBX = 0;
   localparam int ST_RES = 1;
   localparam int ST_TH  = 4;
   localparam int ST_ERR = 6;
   localparam int ST_RUN = 7;
   // ==========================================================
   // Operating modes and commands
   localparam logic [7:0] MODE_SLEEP = 8'h00;
   localparam logic [7:0] MODE_IDLE  = 8'h01;
   localparam logic [7:0] MODE_GAS   = 8'h02;
   localparam logic [7:0] MODE_SWRST = 8'h0f;
   localparam logic [7:0] CMD_NOP    = 8'h00;
   localparam logic [7:0] CMD_FETCH_VERSION = 8'h01;
   localparam logic [7:0] ZERO8      = 8'h00;
   localparam logic [15:0] ZERO16    = 16'h0000;
endpackage : shcsr_pkg

/* rtl/shcsr_sync2.sv */
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module shcsr_sync2 #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic async_in,
   output logic      sync_out
);
   logic meta_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q   <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : shcsr_sync2
`default_nettype wire

/* tb/shcsr_properties.sv */
// Concurrent checks on the register bus and alert pin between host and sensor
`timescale 1ns/1ns
`default_nettype none
module shcsr_props (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       alert_pin_n_o,
   input wire logic       alert_pin_n_oe,
   input wire logic       alert_pin_n_level
);
   logic [7:0] cfg_q;
   logic [7:0] mode_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Shadows of host writes; invalid mode codes leave the mode alone
   always_ff @(posedge clk) begin
      if (sys_rst || (wr && addr == shcsr_pkg::A_OPERATING_MODE_REG && wdata == shcsr_pkg::MODE_SWRST)) begin
         cfg_q  <= 8'h00;
         mode_q <= shcsr_pkg::MODE_IDLE;
      end else if (wr && addr == shcsr_pkg::A_CONFIG) begin
         cfg_q <= wdata & shcsr_pkg::CFG_MASK;
      end else if (wr && addr == shcsr_pkg::A_OPERATING_MODE_REG && wdata <= shcsr_pkg::MODE_GAS) begin
         mode_q <= wdata;
      end
   end
   // ==========================================================
   // Sequences
   sequence s_quiet4;
      (!rd && !wr) [*4];
   endsequence
   sequence s_stat_rd;
      rd && addr == shcsr_pkg::A_STATUS;
   endsequence
   sequence s_fetch;
      wr && addr == shcsr_pkg::A_COMMAND && wdata == shcsr_pkg::CMD_FETCH_VERSION
         && mode_q == shcsr_pkg::MODE_IDLE;
   endsequence
   // ==========================================================
   // Assertions
   a_cfg_readback: assert property (rd && addr == shcsr_pkg::A_CONFIG |=> rdata == $past(cfg_q))
      else $error("config read back wrong");
   a_unmapped_zero: assert property (rd && addr inside {[8'h17:8'h1f]} |=> rdata == 8'h00)
      else $error("reserved address read not zero");
   a_status_resvd: assert property (s_stat_rd |=> (rdata & 8'h2c) == 8'h00)
      else $error("reserved status bits set");
   a_run_flag: assert property (s_stat_rd |=> rdata[7] == ($past(mode_q) == shcsr_pkg::MODE_GAS))
      else $error("running flag disagrees with mode");
   a_fetch_flag: assert property (s_fetch ##1 s_quiet4 ##1 s_stat_rd |=> rdata[0])
      else $error("version fetch left mailbox flag low");
   a_mbox_clear: assert property (rd && addr == shcsr_pkg::A_RMBOX ##1 s_quiet4 ##1 s_stat_rd
      |=> !rdata[0]) else $error("mailbox flag not cleared by read");
   a_push_pull: assert property (cfg_q[5] && $past(cfg_q[5]) |-> alert_pin_n_oe)
      else $error("push-pull pin not driven");
   a_open_drain: assert property (!cfg_q[5] && !$past(cfg_q[5]) |-> !alert_pin_n_o)
      else $error("open-drain pin drives high");
   a_master_off: assert property (!cfg_q[0] && !$past(cfg_q[0]) && $stable(cfg_q[6])
      |-> alert_pin_n_level == !cfg_q[6]) else $error("alert active while disabled");
endmodule : shcsr_props
`default_nettype wire

/* tb/shcsr_tb_top.sv */
// Self-checking bench: host and sensor register bank joined by their bus
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t got %h want %h", $time, (g), (e)); end end
module shcsr_tb_top;
   localparam logic W = 1'b0;
   localparam logic R = 1'b1;
   typedef struct packed {
      logic       k;
      logic [7:0] a;
      logic [7:0] d;
   } shcsr_row_t;
   logic        clk           = 1'b0;
   logic        sys_rst       = 1'b1;
   logic [7:0]  user_addr     = 8'h00;
   logic [7:0]  user_wdata    = 8'h00;
   logic [15:0] user_wdata16  = 16'h0000;
   logic        user_wr       = 1'b0;
   logic        user_word_wr  = 1'b0;
   logic        user_rd       = 1'b0;
   logic [15:0] result_tvoc   = 16'h1234;
   logic [15:0] result_eco2   = 16'h5678;
   logic        result_load   = 1'b0;
   logic        threshold_hit = 1'b0;
   logic [7:0]  user_rdata;
   logic        user_rvalid;
   logic        alert_seen;
   logic [15:0] temp_comp;
   logic [15:0] rh_comp;
   logic        comp_update;
   logic        busy;
   logic [7:0]  op_mode;
   int          n_errors      = 0;
   int          n_checks      = 0;
   int          n_comp        = 0;
   int          n_busy        = 0;
   // ==========================================================
   // Ordinary cases: reset values, masks, modes, error, version fetch
   shcsr_row_t  rows [35] = '{
      '{R, 8'h11, 8'h00}, '{R, 8'h12, 8'h00}, '{R, 8'h13, 8'h00}, '{R, 8'h15, 8'h00},
      '{R, 8'h20, 8'h00}, '{R, 8'h10, 8'h01}, '{W, 8'h11, 8'hff}, '{R, 8'h11, 8'h6f},
      '{W, 8'h20, 8'hff}, '{R, 8'h20, 8'h00}, '{R, 8'h17, 8'h00}, '{W, 8'h10, 8'h00},
      '{R, 8'h20, 8'h00}, '{W, 8'h10, 8'h02}, '{R, 8'h20, 8'h80}, '{W, 8'h10, 8'h0f},
      '{R, 8'h10, 8'h01}, '{R, 8'h11, 8'h00}, '{W, 8'h10, 8'h05}, '{R, 8'h20, 8'h41},
      '{R, 8'h48, 8'h05}, '{R, 8'h20, 8'h40}, '{W, 8'h10, 8'h01}, '{R, 8'h20, 8'h00},
      '{W, 8'h12, 8'h01}, '{R, 8'h20, 8'h01}, '{R, 8'h48, 8'h10}, '{R, 8'h49, 8'h00},
      '{R, 8'h20, 8'h00}, '{W, 8'h12, 8'h77}, '{R, 8'h20, 8'h40}, '{R, 8'h48, 8'h10},
      '{R, 8'h12, 8'h77}, '{W, 8'h10, 8'h01}, '{R, 8'h20, 8'h00}};

   always #10 clk = ~clk;

   // Count the one-cycle pulses so they can be checked after the fact
   always @(posedge clk) begin
      if (comp_update) begin
         n_comp <= n_comp + 1;
      end
      if (busy) begin
         n_busy <= n_busy + 1;
      end
   end

   shcsr_if bus_if ();
   shcsr_device u_shcsr_device (
      .clk                (clk),
      .sys_rst            (sys_rst),
      .bus                (bus_if),
      .result_tvoc        (result_tvoc),
      .result_eco2        (result_eco2),
      .result_load        (result_load),
      .threshold_hit      (threshold_hit),
      .operating_mode_reg (op_mode),
      .temp_comp          (temp_comp),
      .rh_comp            (rh_comp),
      .comp_update        (comp_update)
   );
   shcsr_host u_shcsr_host (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .bus          (bus_if),
      .user_addr    (user_addr),
      .user_wdata   (user_wdata),
      .user_wdata16 (user_wdata16),
      .user_wr      (user_wr),
      .user_word_wr (user_word_wr),
      .user_rd      (user_rd),
      .user_rdata   (user_rdata),
      .user_rvalid  (user_rvalid),
      .busy         (busy),
      .alert_seen   (alert_seen)
   );
   shcsr_props u_shcsr_props (
      .clk               (clk),
      .sys_rst           (sys_rst),
      .addr              (bus_if.addr),
      .wdata             (bus_if.wdata),
      .wr                (bus_if.wr),
      .rd                (bus_if.rd),
      .rdata             (bus_if.rdata),
      .alert_pin_n_o     (bus_if.alert_pin_n_o),
      .alert_pin_n_oe    (bus_if.alert_pin_n_oe),
      .alert_pin_n_level (bus_if.alert_pin_n_level)
   );
   // ==========================================================
   // Host tasks; every byte access leaves four idle bus cycles behind it, a word write three
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   task automatic put(input logic wd, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      user_wr      <= !wd;
      user_word_wr <= wd;
      user_addr    <= a;
      user_wdata   <= d[7:0];
      user_wdata16 <= d;
      @(posedge clk);
      user_wr      <= 1'b0;
      user_word_wr <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : put

   task automatic get(input logic [7:0] a, input logic [7:0] e);
      int i;
      @(posedge clk);
      user_rd   <= 1'b1;
      user_addr <= a;
      @(posedge clk);
      user_rd <= 1'b0;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (user_rvalid !== 1'b1 && i < 8);
      if (i == 8) begin
         n_errors++;
         complete_run();
      end
      `CHK(user_rdata, e)
   endtask : get

   task automatic see(input logic e);
      int i;
      for (i = 0; i < 20 && alert_seen !== e; i++) @(posedge clk);
      if (i == 20) begin
         n_errors++;
         complete_run();
      end
      `CHK(alert_seen, e)
   endtask : see

   task automatic kick(input logic thr);
      @(posedge clk);
      result_load   <= !thr;
      threshold_hit <= thr;
      @(posedge clk);
      result_load   <= 1'b0;
      threshold_hit <= 1'b0;
   endtask : kick
   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].k == R) begin
            get(rows[i].a, rows[i].d);
         end else begin
            put(1'b0, rows[i].a, {8'h00, rows[i].d});
         end
      end
      $display("table test done");
      put(1'b1, 8'h13, 16'h4a8a);
      `CHK(temp_comp, 16'h4a8a)
      put(1'b0, 8'h14, 16'h004b);
      `CHK(temp_comp, 16'h4b8a)
      get(8'h13, 8'h8a);
      put(1'b1, 8'h15, 16'h6400);
      `CHK(rh_comp, 16'h6400)
      put(1'b0, 8'h15, 16'h0080);
      `CHK(rh_comp, 16'h6400)
      `CHK(n_comp, 3)
      `CHK(n_busy, 2)
      $display("compensation test done");
      put(1'b0, 8'h11, 16'h002b);
      put(1'b0, 8'h12, 16'h0001);
      see(1'b1);
      `CHK(bus_if.alert_pin_n_level, 1'b0)
      get(8'h48, 8'h10);
      see(1'b0);
      kick(1'b0);
      see(1'b1);
      get(8'h22, 8'h34);
      see(1'b0);
      put(1'b0, 8'h11, 16'h002a);
      kick(1'b0);
      repeat (8) @(posedge clk);
      `CHK(alert_seen, 1'b0)
      get(8'h20, 8'h02);
      get(8'h25, 8'h56);
      put(1'b0, 8'h11, 16'h0045);
      kick(1'b1);
      see(1'b1);
      `CHK(bus_if.alert_pin_n_level, 1'b1)
      get(8'h20, 8'h10);
      see(1'b0);
      `CHK(bus_if.alert_pin_n_level, 1'b0)
      $display("alert test done");
      // Command waits while a sensing mode runs
      put(1'b0, 8'h40, 16'h00a5);
      get(8'h40, 8'ha5);
      put(1'b0, 8'h10, 16'h0002);
      `CHK(op_mode, 8'h02)
      put(1'b0, 8'h12, 16'h0001);
      get(8'h20, 8'h80);
      put(1'b0, 8'h10, 16'h0001);
      get(8'h20, 8'h01);
      get(8'h48, 8'h10);
      $display("idle command test done");
      put(1'b0, 8'h11, 16'h006f);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      get(8'h11, 8'h00);
      get(8'h20, 8'h00);
      `CHK(op_mode, 8'h01)
      $display("reset test done");
      complete_run();
   end
endmodule : shcsr_tb_top
`default_nettype wire
